// ==== verilog/timer_defines.svh ====
// register map, field positions and reset values of the capture/match timer
//
// Operation
// - Count advances on bus clock cycles or on edges of a chosen capture input.
// - Four match registers; on match continue, stop or reset, optional interrupt.
// - Four 32-bit capture channels latch the count on input transitions, optional interrupt.
// - Only one capture input at a time can be the event source for counting.
// - Capture inputs not used for counting keep working as capture channels.
// - Counter is a 32-bit register fed through a programmable 32-bit prescaler.
// - Four match outputs; on match each goes low, high, toggles or holds.
// - Several pins per capture or match function: inputs OR/AND combined, outputs broadcast.
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

`define TMR_NCH 4
`define TMR_AW 8
`define TMR_DW 32

`define TMR_OFF_CTRL 8'h00
`define TMR_OFF_COUNT 8'h04
`define TMR_OFF_PRE_LIM 8'h08
`define TMR_OFF_PRE_CNT 8'h0C
`define TMR_OFF_MODE 8'h10
`define TMR_OFF_MATCH_CTL 8'h14
`define TMR_OFF_CAP_CTL 8'h18
`define TMR_OFF_EXT_CTL 8'h1C
`define TMR_OFF_INT_STAT 8'h20
`define TMR_OFF_INT_MASK 8'h24
`define TMR_OFF_MR0 8'h28
`define TMR_OFF_MR1 8'h2C
`define TMR_OFF_MR2 8'h30
`define TMR_OFF_MR3 8'h34
`define TMR_OFF_CAP0 8'h38
`define TMR_OFF_CAP1 8'h3C
`define TMR_OFF_CAP2 8'h40
`define TMR_OFF_CAP3 8'h44

// control register bits
`define TMR_CTRL_EN 0
`define TMR_CTRL_CRST 1
// mode register fields
`define TMR_MODE_SRC 0
`define TMR_MODE_SEL 2
// per-channel match control: 3 bits each
`define TMR_MC_W 3
`define TMR_MC_INT 0
`define TMR_MC_RST 1
`define TMR_MC_STOP 2
// per-channel capture control: 4 bits each
`define TMR_CC_W 4
`define TMR_CC_RISE 0
`define TMR_CC_FALL 1
`define TMR_CC_INT 2
`define TMR_CC_AND 3
// external match control: state in low bits, 2-bit actions above
`define TMR_EXT_ACT 4
`define TMR_ACT_W 2
// interrupt status: match bits low, capture bits above
`define TMR_INT_CAP 4
`define TMR_INT_W 8

`define TMR_ZERO32 32'h0000_0000
`define TMR_ONE32 32'h0000_0001

`endif

// ==== verilog/timer_pkg.sv ====
// types shared by the capture/match timer
package timer_pkg;

  typedef enum logic [1:0] {
    SRC_TIMER = 2'h0,
    SRC_RISE = 2'h1,
    SRC_FALL = 2'h2,
    SRC_BOTH = 2'h3
  } src_mode_type;

  typedef enum logic [1:0] {
    ACT_NONE = 2'h0,
    ACT_LOW = 2'h1,
    ACT_HIGH = 2'h2,
    ACT_TOGGLE = 2'h3
  } ext_action_type;

endpackage : timer_pkg

// ==== verilog/capture_channel.sv ====
// one capture channel: pin combine, edge detect and snapshot register
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.svh"

module capture_channel
  import timer_pkg::*;
#(
  parameter int PINS = 2
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pins and settings
  input wire logic [PINS-1:0] pins,
  input wire logic and_mode,
  input wire logic rise_en,
  input wire logic fall_en,
  input wire logic [`TMR_DW-1:0] count,
  // results
  output logic rise,
  output logic fall,
  output logic cap_evt,
  output logic [`TMR_DW-1:0] cap_q
);

  logic lvl;
  logic lvl_q;
  logic [`TMR_DW-1:0] cap_d;

  always_comb
  begin
    lvl = and_mode ? (&pins) : (|pins);
    rise = lvl & ~lvl_q;
    fall = ~lvl & lvl_q;
    cap_evt = (rise & rise_en) | (fall & fall_en);
    cap_d = cap_evt ? count : cap_q;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lvl_q <= 1'b0;
      cap_q <= `TMR_ZERO32;
    end
    else
    begin
      lvl_q <= lvl;
      cap_q <= cap_d;
    end
  end

endmodule : capture_channel
`default_nettype wire

// ==== verilog/capture_match_timer_counter.sv ====
// capture/match timer-counter with prescaler and APB register slave
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.svh"

module capture_match_timer_counter
  import timer_pkg::*;
#(
  parameter int PINS = 2
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`TMR_AW-1:0] paddr,
  input wire logic [`TMR_DW-1:0] pwdata,
  output logic [`TMR_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // capture pins, PINS per channel
  input wire logic [`TMR_NCH*PINS-1:0] cap_pins,
  // match outputs and their broadcast copies
  output logic [`TMR_NCH-1:0] match_out,
  output logic [`TMR_NCH*PINS-1:0] match_pins,
  // interrupt
  output logic irq
);

  localparam int NCH = `TMR_NCH;

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic en_q, en_d, crst_q, crst_d;
  logic [`TMR_DW-1:0] tc_q, tc_d, pr_q, pr_d, pc_q, pc_d;
  logic [1:0] src_q, src_d, sel_q, sel_d;
  logic [NCH*`TMR_MC_W-1:0] mctl_q, mctl_d;
  logic [NCH*`TMR_CC_W-1:0] cctl_q, cctl_d;
  logic [NCH*`TMR_ACT_W-1:0] act_q, act_d;
  logic [NCH-1:0] mo_q, mo_d;
  logic [`TMR_INT_W-1:0] st_q, st_d, mask_q, mask_d;
  logic [`TMR_DW-1:0] mr_q [NCH];
  logic [`TMR_DW-1:0] mr_d [NCH];
  logic rdy_q, rdy_d, err_q, err_d, irq_q, irq_d;
  logic [`TMR_DW-1:0] rd_q, rd_d;
  logic [NCH*PINS-1:0] mpin_q, mpin_d;

  // channel signals
  logic [NCH-1:0] c_rise, c_fall, c_evt, hit;
  logic [`TMR_DW-1:0] cap_val [NCH];
  logic tick, run, adv, rst_hit, stop_hit;
  logic ask, wr, mapped;
  logic [`TMR_DW-1:0] rmux;

  ////////////////////////////////////////////////////////////////////////////
  // capture channels: all stay live, also beside the counting input
  for (genvar g = 0; g < NCH; g++)
  begin : g_cap
    capture_channel #(.PINS(PINS)) u_cap (
      .pclk(pclk),
      .presetn(presetn),
      .pins(cap_pins[g*PINS +: PINS]),
      .and_mode(cctl_q[g*`TMR_CC_W + `TMR_CC_AND]),
      .rise_en(cctl_q[g*`TMR_CC_W + `TMR_CC_RISE]),
      .fall_en(cctl_q[g*`TMR_CC_W + `TMR_CC_FALL]),
      .count(tc_q),
      .rise(c_rise[g]),
      .fall(c_fall[g]),
      .cap_evt(c_evt[g]),
      .cap_q(cap_val[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // count source, prescaler and match detect
  always_comb
  begin
    // a single 2-bit select names the event input, so never two at once
    case (src_mode_type'(src_q))
      SRC_TIMER: tick = 1'b1;
      SRC_RISE: tick = c_rise[sel_q];
      SRC_FALL: tick = c_fall[sel_q];
      SRC_BOTH: tick = c_rise[sel_q] | c_fall[sel_q];
      default: tick = 1'b0;
    endcase
    run = en_q & ~crst_q;
    adv = run & tick & (pc_q == pr_q);
    for (int i = 0; i < NCH; i++)
      hit[i] = adv & (tc_q == mr_q[i]);
    rst_hit = |(hit & {mctl_q[3*`TMR_MC_W + `TMR_MC_RST], mctl_q[2*`TMR_MC_W + `TMR_MC_RST],
      mctl_q[`TMR_MC_W + `TMR_MC_RST], mctl_q[`TMR_MC_RST]});
    stop_hit = |(hit & {mctl_q[3*`TMR_MC_W + `TMR_MC_STOP], mctl_q[2*`TMR_MC_W + `TMR_MC_STOP],
      mctl_q[`TMR_MC_W + `TMR_MC_STOP], mctl_q[`TMR_MC_STOP]});
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb decode: one wait state so read data leaves a flop
  always_comb
  begin
    ask = psel & penable & ~rdy_q;
    wr = psel & penable & rdy_q & pwrite;
    mapped = 1'b1;
    rmux = `TMR_ZERO32;
    case (paddr)
      `TMR_OFF_CTRL: rmux = {30'h0000_0000, crst_q, en_q};
      `TMR_OFF_COUNT: rmux = tc_q;
      `TMR_OFF_PRE_LIM: rmux = pr_q;
      `TMR_OFF_PRE_CNT: rmux = pc_q;
      `TMR_OFF_MODE: rmux = {28'h000_0000, sel_q, src_q};
      `TMR_OFF_MATCH_CTL: rmux = {20'h0_0000, mctl_q};
      `TMR_OFF_CAP_CTL: rmux = {16'h0000, cctl_q};
      `TMR_OFF_EXT_CTL: rmux = {20'h0_0000, act_q, mo_q};
      `TMR_OFF_INT_STAT: rmux = {24'h00_0000, st_q};
      `TMR_OFF_INT_MASK: rmux = {24'h00_0000, mask_q};
      `TMR_OFF_MR0: rmux = mr_q[0];
      `TMR_OFF_MR1: rmux = mr_q[1];
      `TMR_OFF_MR2: rmux = mr_q[2];
      `TMR_OFF_MR3: rmux = mr_q[3];
      `TMR_OFF_CAP0: rmux = cap_val[0];
      `TMR_OFF_CAP1: rmux = cap_val[1];
      `TMR_OFF_CAP2: rmux = cap_val[2];
      `TMR_OFF_CAP3: rmux = cap_val[3];
      default: mapped = 1'b0;
    endcase
    rdy_d = ask;
    err_d = ask & ~mapped;
    rd_d = ask ? rmux : rd_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state of counter, registers and outputs
  always_comb
  begin
    en_d = en_q;
    crst_d = crst_q;
    tc_d = tc_q;
    pc_d = pc_q;
    pr_d = pr_q;
    src_d = src_q;
    sel_d = sel_q;
    mctl_d = mctl_q;
    cctl_d = cctl_q;
    act_d = act_q;
    mo_d = mo_q;
    mask_d = mask_q;
    st_d = st_q;
    for (int i = 0; i < NCH; i++)
      mr_d[i] = mr_q[i];

    // counter; reset-on-match lands on the step that would pass the match
    if (crst_q)
    begin
      tc_d = `TMR_ZERO32;
      pc_d = `TMR_ZERO32;
    end
    else if (run & tick)
    begin
      if (adv)
      begin
        pc_d = `TMR_ZERO32;
        if (rst_hit)
          tc_d = `TMR_ZERO32;
        else if (!stop_hit)
          tc_d = tc_q + `TMR_ONE32;
        if (stop_hit)
          en_d = 1'b0;
      end
      else
        pc_d = pc_q + `TMR_ONE32;
    end

    // match outputs
    for (int i = 0; i < NCH; i++)
      if (hit[i])
        case (ext_action_type'(act_q[i*`TMR_ACT_W +: `TMR_ACT_W]))
          ACT_LOW: mo_d[i] = 1'b0;
          ACT_HIGH: mo_d[i] = 1'b1;
          ACT_TOGGLE: mo_d[i] = ~mo_q[i];
          default: mo_d[i] = mo_q[i];
        endcase

    // software writes
    if (wr)
      case (paddr)
        `TMR_OFF_CTRL:
        begin
          en_d = pwdata[`TMR_CTRL_EN];
          crst_d = pwdata[`TMR_CTRL_CRST];
        end
        `TMR_OFF_COUNT: tc_d = pwdata;
        `TMR_OFF_PRE_LIM: pr_d = pwdata;
        `TMR_OFF_MODE:
        begin
          src_d = pwdata[`TMR_MODE_SRC +: 2];
          sel_d = pwdata[`TMR_MODE_SEL +: 2];
        end
        `TMR_OFF_MATCH_CTL: mctl_d = pwdata[NCH*`TMR_MC_W-1:0];
        `TMR_OFF_CAP_CTL: cctl_d = pwdata[NCH*`TMR_CC_W-1:0];
        `TMR_OFF_EXT_CTL:
        begin
          mo_d = pwdata[NCH-1:0];
          act_d = pwdata[`TMR_EXT_ACT +: NCH*`TMR_ACT_W];
        end
        `TMR_OFF_INT_MASK: mask_d = pwdata[`TMR_INT_W-1:0];
        `TMR_OFF_MR0: mr_d[0] = pwdata;
        `TMR_OFF_MR1: mr_d[1] = pwdata;
        `TMR_OFF_MR2: mr_d[2] = pwdata;
        `TMR_OFF_MR3: mr_d[3] = pwdata;
        default: ;
      endcase

    // sticky status: write one clears, a same-cycle event still sets
    if (wr && paddr == `TMR_OFF_INT_STAT)
      st_d = st_q & ~pwdata[`TMR_INT_W-1:0];
    for (int i = 0; i < NCH; i++)
    begin
      if (hit[i] & mctl_q[i*`TMR_MC_W + `TMR_MC_INT])
        st_d[i] = 1'b1;
      if (c_evt[i] & cctl_q[i*`TMR_CC_W + `TMR_CC_INT])
        st_d[`TMR_INT_CAP + i] = 1'b1;
    end

    irq_d = |(st_d & mask_d);
    for (int i = 0; i < NCH*PINS; i++)
      mpin_d[i] = mo_d[i / PINS];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_q <= 1'b0;
      crst_q <= 1'b0;
      tc_q <= `TMR_ZERO32;
      pc_q <= `TMR_ZERO32;
      pr_q <= `TMR_ZERO32;
      src_q <= 2'h0;
      sel_q <= 2'h0;
      mctl_q <= '0;
      cctl_q <= '0;
      act_q <= '0;
      mo_q <= '0;
      st_q <= '0;
      mask_q <= '0;
      for (int i = 0; i < NCH; i++)
        mr_q[i] <= `TMR_ZERO32;
      rdy_q <= 1'b0;
      err_q <= 1'b0;
      rd_q <= `TMR_ZERO32;
      irq_q <= 1'b0;
      mpin_q <= '0;
    end
    else
    begin
      en_q <= en_d;
      crst_q <= crst_d;
      tc_q <= tc_d;
      pc_q <= pc_d;
      pr_q <= pr_d;
      src_q <= src_d;
      sel_q <= sel_d;
      mctl_q <= mctl_d;
      cctl_q <= cctl_d;
      act_q <= act_d;
      mo_q <= mo_d;
      st_q <= st_d;
      mask_q <= mask_d;
      for (int i = 0; i < NCH; i++)
        mr_q[i] <= mr_d[i];
      rdy_q <= rdy_d;
      err_q <= err_d;
      rd_q <= rd_d;
      irq_q <= irq_d;
      mpin_q <= mpin_d;
    end
  end

  assign prdata = rd_q;
  assign pready = rdy_q;
  assign pslverr = err_q;
  assign match_out = mo_q;
  assign match_pins = mpin_q;
  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_timer_source: assert property (
    (src_q == SRC_TIMER && run && !wr && pc_q != pr_q) |=> (pc_q == $past(pc_q) + 32'h1))
    else $error("timer mode did not advance on a bus clock cycle");
  chk_event_select: assert property (
    (src_q == SRC_RISE) |-> (tick == c_rise[sel_q]))
    else $error("event tick not from selected input");
  chk_prescale_wrap: assert property (
    (adv && !wr) |=> (pc_q == `TMR_ZERO32))
    else $error("prescaler did not restart");
  chk_prescale_hold: assert property (
    (run && tick && !adv && !wr) |=> (tc_q == $past(tc_q)) && (pc_q == $past(pc_q) + 1))
    else $error("count moved before prescale limit");
  chk_match_reset: assert property (
    (rst_hit && !wr) |=> (tc_q == `TMR_ZERO32))
    else $error("reset on match failed");
  chk_match_stop: assert property (
    (stop_hit && !rst_hit && !wr) |=> !en_q ##1 (tc_q == $past(tc_q, 2)))
    else $error("stop on match failed");
  chk_capture_latch: assert property (
    c_evt[2] |=> (cap_val[2] == $past(tc_q)))
    else $error("capture missed count");
  chk_capture_beside: assert property (
    (src_q != SRC_TIMER && sel_q == 2'h0 && c_evt[3]) |=> (cap_val[3] == $past(tc_q)))
    else $error("unused capture input stopped capturing");
  chk_ext_toggle: assert property (
    (hit[1] && act_q[3:2] == ACT_TOGGLE && !wr) |=> (match_out[1] != $past(match_out[1])))
    else $error("match output did not toggle");
  chk_pin_broadcast: assert property (
    ##1 (match_pins[PINS-1:0] == {PINS{match_out[0]}}))
    else $error("match pins differ from output");
  chk_irq_level: assert property (
    (|(st_q & mask_q)) |-> irq_q || !$past(presetn))
    else $error("irq low with unmasked status");

  cov_match_reset: cover property (rst_hit ##1 (tc_q == `TMR_ZERO32));
  cov_event_count: cover property ((src_q != SRC_TIMER) && adv);
  cov_capture: cover property (c_evt[0] && run);
  cov_irq: cover property ($rose(irq_q));

endmodule : capture_match_timer_counter
`default_nettype wire

// ==== tb/capture_pin_driver.sv ====
// partner model: outside source driving the capture pins
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.svh"

module capture_pin_driver
#(
  parameter int PINS = 2
)
(
  // clock
  input wire logic pclk,
  // pins towards the timer
  output var logic [`TMR_NCH*PINS-1:0] cap_pins
);
  initial cap_pins = '0;

  ////////////////////////////////////////////////////////////////
  // one pulse on a channel; gap of at least one cycle per level
  // keeps the event rate within half the bus clock
  task automatic pulse(input int ch, input logic [PINS-1:0] pm, input int gap);
    repeat (gap) @(posedge pclk);
    cap_pins[ch*PINS+:PINS] <= pm;
    repeat (gap) @(posedge pclk);
    cap_pins[ch*PINS+:PINS] <= '0;
  endtask : pulse
endmodule : capture_pin_driver
`default_nettype wire

// ==== tb/capture_match_timer_counter_tb.sv ====
// self-checking bench of the capture/match timer-counter
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.svh"

module capture_match_timer_counter_tb
  import timer_pkg::*;
;
  localparam int PINS = 2;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [`TMR_AW-1:0] paddr = 8'h00;
  logic [`TMR_DW-1:0] pwdata = 32'h0;
  logic [`TMR_DW-1:0] prdata;
  logic pready;
  logic pslverr;
  wire logic [`TMR_NCH*PINS-1:0] cap_pins;
  logic [`TMR_NCH-1:0] match_out;
  logic [`TMR_NCH*PINS-1:0] match_pins;
  logic irq;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h909E;
  logic [31:0] rd;
  logic er;
  logic [31:0] rv;
  int lim, k, n, i, lo;

  capture_match_timer_counter #(.PINS(PINS)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cap_pins(cap_pins),
    .match_out(match_out), .match_pins(match_pins), .irq(irq));
  capture_pin_driver #(.PINS(PINS)) u_pins (.pclk(pclk), .cap_pins(cap_pins));

  always #25 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic report_and_stop();
    if (fails == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one transfer; an idle edge after it keeps drivers single per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: only the bench timeout ends a hung wait
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc

  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fails++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i <= 'h44; i += 4)
      rdc(i[7:0], 32'h0);
    rdc(8'h48, 32'h0);
    chk({31'h0, er}, 32'h1);
    rv = xs();
    apb(1'b1, `TMR_OFF_MR3, rv);
    rdc(`TMR_OFF_MR3, rv);
    // prescaled timer, stop on MR1 with toggle and unmasked interrupt
    apb(1'b1, `TMR_OFF_MR1, 32'h5);
    apb(1'b1, `TMR_OFF_MATCH_CTL, 32'h28);
    apb(1'b1, `TMR_OFF_EXT_CTL, 32'hC0);
    apb(1'b1, `TMR_OFF_INT_MASK, 32'h2);
    for (lim = 0; lim < 4; lim++)
    begin
      apb(1'b1, `TMR_OFF_PRE_LIM, lim);
      apb(1'b1, `TMR_OFF_CTRL, 32'h2);
      apb(1'b1, `TMR_OFF_INT_STAT, 32'h2);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, `TMR_OFF_CTRL, 32'h1);
      n = 0;
      while (irq !== 1'b1 && n < 500)
      begin
        @(posedge pclk);
        n++;
      end
      lo = 6 * (lim + 1);
      chk({31'h0, n >= lo - 3 && n <= lo + 3}, 32'h1);
      chk({28'h0, match_out}, (lim + 1) % 2 * 2);
    end
    rdc(`TMR_OFF_COUNT, 32'h5);
    rdc(`TMR_OFF_COUNT, 32'h5);
    chk({24'h0, match_pins}, 32'h0);
    // AND-combined capture on channel 2 of the held count
    apb(1'b1, `TMR_OFF_CAP_CTL, 32'hD00);
    u_pins.pulse(2, 2'b01, 2);
    rdc(`TMR_OFF_CAP2, 32'h0);
    u_pins.pulse(2, 2'b11, 2);
    repeat (2) @(posedge pclk);
    rdc(`TMR_OFF_CAP2, 32'h5);
    rdc(`TMR_OFF_INT_STAT, 32'h42);
    apb(1'b1, `TMR_OFF_INT_STAT, 32'h2);
    chk({31'h0, irq}, 32'h0);
    // reset on MR0 at 2; high, low and none actions on outputs 0, 2, 3
    apb(1'b1, `TMR_OFF_MATCH_CTL, 32'h2);
    apb(1'b1, `TMR_OFF_MR0, 32'h2);
    apb(1'b1, `TMR_OFF_EXT_CTL, 32'h12C);
    apb(1'b1, `TMR_OFF_PRE_LIM, 32'h0);
    // counter still holds the stop value; clear it before counting again
    apb(1'b1, `TMR_OFF_CTRL, 32'h2);
    apb(1'b1, `TMR_OFF_CTRL, 32'h1);
    for (i = 0; i < 6; i++)
    begin
      repeat (xs() % 5) @(posedge pclk);
      apb(1'b0, `TMR_OFF_COUNT, 32'h0);
      chk({31'h0, rd <= 32'h2}, 32'h1);
    end
    chk({28'h0, match_out}, 32'h9);
    chk({24'h0, match_pins}, 32'hC3);
    // event counting on channel 0 rises; channel 3 still captures
    apb(1'b1, `TMR_OFF_CTRL, 32'h2);
    apb(1'b1, `TMR_OFF_MATCH_CTL, 32'h0);
    apb(1'b1, `TMR_OFF_MODE, 32'h1);
    apb(1'b1, `TMR_OFF_CAP_CTL, 32'h1000);
    apb(1'b1, `TMR_OFF_CTRL, 32'h1);
    k = 3 + xs() % 6;
    repeat (k) u_pins.pulse(0, 2'b01, 1 + xs() % 3);
    u_pins.pulse(1, 2'b01, 2);
    repeat (3) @(posedge pclk);
    rdc(`TMR_OFF_COUNT, k);
    u_pins.pulse(3, 2'b10, 1);
    repeat (3) @(posedge pclk);
    rdc(`TMR_OFF_CAP3, k);
    // falling-edge and both-edge event counting on the same input
    apb(1'b1, `TMR_OFF_MODE, 32'h2);
    u_pins.pulse(0, 2'b11, 2);
    apb(1'b1, `TMR_OFF_MODE, 32'h3);
    u_pins.pulse(0, 2'b10, 2);
    repeat (3) @(posedge pclk);
    rdc(`TMR_OFF_COUNT, k + 3);
    report_and_stop();
  end
endmodule : capture_match_timer_counter_tb
`default_nettype wire
